// ---- slot_mapper_defines.vh ----
`ifndef SLOT_MAPPER_DEFINES_VH
`define SLOT_MAPPER_DEFINES_VH

// ********************************************************************
// Slot numbering
// ********************************************************************
`define ACCESS_POINT_SLOT 4'h0
`define ACCESS_POINT_SUBSLOT 4'h1
`define NUM_DATA_SLOTS 9
`define FIRST_INT_IN_SLOT 4'h1
`define LAST_INT_IN_SLOT 4'h3
`define FIRST_FLT_IN_SLOT 4'h4
`define LAST_FLT_IN_SLOT 4'h6
`define FIRST_INT_OUT_SLOT 4'h7
`define LAST_INT_OUT_SLOT 4'h9

// ********************************************************************
// Module identifiers, base of each family, low two bits pick size
// ********************************************************************
`define MOD_ID_INT_IN_BASE 8'h30
`define MOD_ID_FLT_IN_BASE 8'h34
`define MOD_ID_INT_OUT_BASE 8'h40
`define MOD_ID_EMPTY 8'h00

// ********************************************************************
// Sizes in local registers (two bytes each) by size code
// ********************************************************************
`define REGS_SIZE0 16'h0100
`define REGS_SIZE1 16'h0080
`define REGS_SIZE2 16'h0040
`define REGS_SIZE3 16'h0020

// ********************************************************************
// Local register start numbers per family
// ********************************************************************
`define INT_IN_START 16'h0001
`define FLT_IN_START 16'h03E9
`define INT_OUT_START 16'h1389

`endif

// ---- module_id_check.v ----
`timescale 1ns/1ps

// ********************************************************************
// Checks a plugged module identifier against its slot
// ********************************************************************
`include "slot_mapper_defines.vh"

module module_id_check (
   input wire [3:0] slot,
   input wire [7:0] mod_id,
   output reg ok,
   output reg [1:0] size_code
);

   reg [7:0] base;

   // Family base follows the slot range; slot 0 and above 9 take none
   always @* begin
      base = `MOD_ID_EMPTY;
      size_code = mod_id[1:0];
      if (slot >= `FIRST_INT_IN_SLOT && slot <= `LAST_INT_IN_SLOT) begin
         base = `MOD_ID_INT_IN_BASE;
      end else if (slot >= `FIRST_FLT_IN_SLOT &&
                   slot <= `LAST_FLT_IN_SLOT) begin
         base = `MOD_ID_FLT_IN_BASE;
      end else if (slot >= `FIRST_INT_OUT_SLOT &&
                   slot <= `LAST_INT_OUT_SLOT) begin
         base = `MOD_ID_INT_OUT_BASE;
      end
      // Access point slot never takes data modules
      ok = (base != `MOD_ID_EMPTY) &&
           ({mod_id[7:2], 2'b00} == base);
   end

endmodule // module_id_check

// ---- regs_of_size.v ----
`timescale 1ns/1ps

// ********************************************************************
// Module size code to count of two-byte local registers
// ********************************************************************
`include "slot_mapper_defines.vh"

module regs_of_size (
   input wire [1:0] size_code,
   output reg [15:0] regs
);

   // 512, 256, 128, 64 bytes; two bytes per register
   always @* begin
      case (size_code)
         2'h0: regs = `REGS_SIZE0;
         2'h1: regs = `REGS_SIZE1;
         2'h2: regs = `REGS_SIZE2;
         2'h3: regs = `REGS_SIZE3;
         default: regs = `REGS_SIZE0;
      endcase
   end

endmodule // regs_of_size

// ---- process_data_slot_mapper.v ----
`timescale 1ns/1ps

`include "slot_mapper_defines.vh"

// Contract
// - Slot 0 subslot 1 is access point only
// - Exactly nine process data slots
// - Module sizes 64, 128, 256, 512 bytes
// - Each local register is two bytes
// - Slots 1-3 integer inputs, ids 0x30-0x33
// - Slots 4-6 float inputs, ids 0x34-0x37
// - Slots 7-9 integer outputs, ids 0x40-0x43
// - Integer inputs read from registers each cycle; the code reads them only on each IN_REQ
// - Outputs written to registers from 5001
// - Integer inputs packed from register 1
// - Floats from two registers, from 1001
// - Network address only from controller once enabled
module process_data_slot_mapper #(
   parameter NSLOT = `NUM_DATA_SLOTS,
   parameter RW = 16
) (
   input wire CLK,
   input wire RST,
   // Configuration of one slot by the controller
   input wire CFG_VALID,
   input wire [3:0] CFG_SLOT,
   input wire [3:0] CFG_SUBSLOT,
   input wire [7:0] CFG_MOD_ID,
   output wire CFG_READY,
   output reg CFG_ACCEPT,
   output reg CFG_REJECT,
   output reg [NSLOT-1:0] SLOT_BAD,
   output reg [NSLOT-1:0] SLOT_PLUGGED,
   // Input data request: slot and word index within module
   input wire IN_REQ,
   input wire [3:0] IN_SLOT,
   input wire [7:0] IN_INDEX,
   output reg IN_ACK,
   output reg IN_ERR,
   output reg [31:0] IN_DATA,
   // Local register read port, one cycle latency
   output wire LR_RD_EN,
   output wire [15:0] LR_RD_ADDR,
   input wire [RW-1:0] LR_RD_DATA,
   // Output data from controller, one register per beat
   input wire OUT_VALID,
   input wire [3:0] OUT_SLOT,
   input wire [7:0] OUT_INDEX,
   input wire [RW-1:0] OUT_DATA,
   output wire OUT_READY,
   output reg OUT_ERR,
   // Local register write port
   output reg LR_WR_EN,
   output reg [15:0] LR_WR_ADDR,
   output reg [RW-1:0] LR_WR_DATA,
   // Network address
   input wire PROTO_EN,
   input wire LOCAL_ADDR_VALID,
   input wire [31:0] LOCAL_ADDR,
   input wire CTRL_ADDR_VALID,
   input wire [31:0] CTRL_ADDR,
   output reg [31:0] NET_ADDR
);

   // *****************************************************************
   // Slot table
   // *****************************************************************
   // Size codes outlive an unplug; they still set the packing
   reg [1:0] size_r [0:NSLOT-1];
   wire id_ok;
   wire [1:0] id_size;
   wire [3:0] idx;
   integer i;
   integer j;

   module_id_check u_chk (
      .slot(CFG_SLOT),
      .mod_id(CFG_MOD_ID),
      .ok(id_ok),
      .size_code(id_size)
   );

   // Slot number 1..9 to table index 0..8
   function [3:0] slot_idx;
      input [3:0] s;
      begin
         slot_idx = s - 4'h1;
      end
   endfunction

   // True for a process data slot 1..9
   function in_range;
      input [3:0] s;
      begin
         in_range = (s >= 4'h1) && (s <= NSLOT);
      end
   endfunction

   // Subslot is not decoded: slot 0 is refused whatever its subslot
   assign CFG_READY = 1'b1;
   // Index is out of range for slot 0 and above 9; only used in range
   assign idx = slot_idx(CFG_SLOT);

   // *****************************************************************
   // Plug handling
   // *****************************************************************
   // Plug or refuse modules; the access point is never a data slot
   // A refused plug also unplugs the slot, so stale data cannot flow
   always @(posedge CLK) begin
      CFG_ACCEPT <= 1'b0;
      CFG_REJECT <= 1'b0;
      if (RST) begin
         SLOT_BAD <= {NSLOT{1'b0}};
         SLOT_PLUGGED <= {NSLOT{1'b0}};
         for (i = 0; i < NSLOT; i = i + 1) begin
            size_r[i] <= 2'h0;
         end
      end else if (CFG_VALID) begin
         if (CFG_SLOT == `ACCESS_POINT_SLOT) begin
            CFG_REJECT <= 1'b1;
         end else if (!in_range(CFG_SLOT)) begin
            CFG_REJECT <= 1'b1;
         end else if (id_ok) begin
            CFG_ACCEPT <= 1'b1;
            SLOT_PLUGGED[idx] <= 1'b1;
            SLOT_BAD[idx] <= 1'b0;
            size_r[idx] <= id_size;
         end else begin
            CFG_REJECT <= 1'b1;
            SLOT_PLUGGED[idx] <= 1'b0;
            SLOT_BAD[idx] <= 1'b1;
         end
      end
   end

   // *****************************************************************
   // Register base of each slot, packed by configured sizes
   // *****************************************************************
   wire [15:0] regs [0:NSLOT-1];
   reg [15:0] base [0:NSLOT-1];
   genvar g;

   generate
      for (g = 0; g < NSLOT; g = g + 1) begin : g_sz
         regs_of_size u_sz (
            .size_code(size_r[g]),
            .regs(regs[g])
         );
      end
   endgenerate

   // Each family starts at its own register; slots pack back to back
   // Unplugged slots keep their stored size, so unplugging one
   // never moves the data of its neighbours
   always @* begin
      for (j = 0; j < NSLOT; j = j + 1) begin
         if (j == 0) begin
            base[j] = `INT_IN_START;
         end else if (j == 3) begin
            base[j] = `FLT_IN_START;
         end else if (j == 6) begin
            base[j] = `INT_OUT_START;
         end else begin
            base[j] = base[j-1] + regs[j-1];
         end
      end
   end

   // *****************************************************************
   // Input path: integer one register, float two registers
   // *****************************************************************
   // One-hot states; the second read state is taken by floats only
   localparam S_IDLE = 4'b0001;
   localparam S_RD0 = 4'b0010;
   localparam S_RD1 = 4'b0100;
   localparam S_DONE = 4'b1000;

   reg [3:0] st_r;
   reg [15:0] addr_r;
   reg is_flt_r;
   reg [RW-1:0] hi_r;
   wire [3:0] iidx;
   wire in_flt;
   wire in_int;
   wire [15:0] limit;
   wire [15:0] word_off;

   assign iidx = slot_idx(IN_SLOT);
   assign in_int = (IN_SLOT >= `FIRST_INT_IN_SLOT) &&
                   (IN_SLOT <= `LAST_INT_IN_SLOT);
   assign in_flt = (IN_SLOT >= `FIRST_FLT_IN_SLOT) &&
                   (IN_SLOT <= `LAST_FLT_IN_SLOT);
   // Limit counts registers; non-input slots give zero
   assign limit = (in_int || in_flt) ? regs[iidx] : 16'h0000;
   // A float occupies two registers, so its index is doubled
   assign word_off = in_flt ? {7'h00, IN_INDEX, 1'b0}
                            : {8'h00, IN_INDEX};
   assign LR_RD_EN = (st_r == S_RD0) || (st_r == S_RD1);
   assign LR_RD_ADDR = addr_r;

   // Integer words read fresh on every exchange request
   // A request while busy is dropped; the controller waits for ACK
   always @(posedge CLK) begin
      if (RST) begin
         st_r <= S_IDLE;
         addr_r <= 16'h0000;
         is_flt_r <= 1'b0;
         hi_r <= {RW{1'b0}};
         IN_ACK <= 1'b0;
         IN_ERR <= 1'b0;
         IN_DATA <= 32'h00000000;
      end else begin
         IN_ACK <= 1'b0;
         IN_ERR <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (IN_REQ) begin
                  if ((in_int || in_flt) && SLOT_PLUGGED[iidx] &&
                      word_off < limit) begin
                     addr_r <= base[iidx] + word_off;
                     is_flt_r <= in_flt;
                     st_r <= S_RD0;
                  end else begin
                     IN_ACK <= 1'b1;
                     IN_ERR <= 1'b1;
                  end
               end
            end
            S_RD0: begin
               if (is_flt_r) begin
                  addr_r <= addr_r + 16'h0001;
                  st_r <= S_RD1;
               end else begin
                  st_r <= S_DONE;
               end
            end
            S_RD1: begin
               hi_r <= LR_RD_DATA; // First register is the high half
               st_r <= S_DONE;
            end
            S_DONE: begin
               IN_ACK <= 1'b1;
               if (is_flt_r) begin
                  IN_DATA <= {hi_r, LR_RD_DATA};
               end else begin
                  IN_DATA <= {16'h0000, LR_RD_DATA};
               end
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // *****************************************************************
   // Output path: controller data into local registers
   // *****************************************************************
   wire [3:0] oidx;
   wire out_ok;

   assign oidx = slot_idx(OUT_SLOT);
   assign out_ok = (OUT_SLOT >= `FIRST_INT_OUT_SLOT) &&
                   (OUT_SLOT <= `LAST_INT_OUT_SLOT) &&
                   SLOT_PLUGGED[oidx] &&
                   ({8'h00, OUT_INDEX} < regs[oidx]);
   assign OUT_READY = 1'b1;

   // Bad beats are dropped and flagged rather than stored
   // The store must take the write in the cycle it is shown
   always @(posedge CLK) begin
      if (RST) begin
         LR_WR_EN <= 1'b0;
         LR_WR_ADDR <= 16'h0000;
         LR_WR_DATA <= {RW{1'b0}};
         OUT_ERR <= 1'b0;
      end else begin
         LR_WR_EN <= OUT_VALID && out_ok;
         OUT_ERR <= OUT_VALID && !out_ok;
         if (OUT_VALID && out_ok) begin
            LR_WR_ADDR <= base[oidx] + {8'h00, OUT_INDEX};
            LR_WR_DATA <= OUT_DATA;
         end
      end
   end

   // *****************************************************************
   // Network address source
   // *****************************************************************
   // Local settings lose all say once the protocol is on
   // The last address stands until a strobe of the live source
   always @(posedge CLK) begin
      if (RST) begin
         NET_ADDR <= 32'h00000000;
      end else if (PROTO_EN) begin
         if (CTRL_ADDR_VALID) begin
            NET_ADDR <= CTRL_ADDR;
         end
      end else if (LOCAL_ADDR_VALID) begin
         NET_ADDR <= LOCAL_ADDR;
      end
   end

endmodule // process_data_slot_mapper

// ---- slot_mapper_assertions.sv ----
`timescale 1ns/1ps
// ****
// Slot mapper port checks
// ****
module slot_mapper_assertions #(
   parameter NSLOT = 9,
   parameter RW = 16
) (
   input wire CLK,
   input wire RST,
   input wire CFG_VALID,
   input wire [3:0] CFG_SLOT,
   input wire [7:0] CFG_MOD_ID,
   input wire CFG_ACCEPT,
   input wire CFG_REJECT,
   input wire [NSLOT-1:0] SLOT_PLUGGED,
   input wire OUT_VALID,
   input wire [3:0] OUT_SLOT,
   input wire [7:0] OUT_INDEX,
   input wire LR_WR_EN,
   input wire [15:0] LR_WR_ADDR,
   input wire PROTO_EN,
   input wire CTRL_ADDR_VALID,
   input wire [31:0] CTRL_ADDR,
   input wire [31:0] NET_ADDR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Family code: id without its two size bits
   wire [5:0] fam = CFG_MOD_ID[7:2];
   chk_ap_refused: assert property (
      CFG_VALID && CFG_SLOT == 4'h0 |=> CFG_REJECT && !CFG_ACCEPT)
      else $error("access point slot not refused");
   chk_slot_range: assert property (
      CFG_VALID && CFG_SLOT > 4'h9 |=> CFG_REJECT)
      else $error("slot above nine not refused");
   chk_int_in_ok: assert property (
      CFG_VALID && CFG_SLOT inside {[1:3]} && fam == 6'h0C |=> CFG_ACCEPT)
      else $error("integer input module not taken");
   chk_flt_in_ok: assert property (
      CFG_VALID && CFG_SLOT inside {[4:6]} && fam == 6'h0D |=> CFG_ACCEPT)
      else $error("float input module not taken");
   chk_int_out_ok: assert property (
      CFG_VALID && CFG_SLOT inside {[7:9]} && fam == 6'h10 |=> CFG_ACCEPT)
      else $error("integer output module not taken");
   chk_bad_id_flag: assert property (
      CFG_VALID && CFG_SLOT inside {[1:3]} && fam != 6'h0C |=> CFG_REJECT)
      else $error("wrong module id not refused");
   chk_out_base: assert property (
      OUT_VALID && OUT_SLOT == 4'h7 && SLOT_PLUGGED[6] && OUT_INDEX == 8'h00
      |=> LR_WR_EN && LR_WR_ADDR == 16'h1389)
      else $error("first output word not at its base");
   chk_ctrl_addr: assert property (
      PROTO_EN && CTRL_ADDR_VALID |=> NET_ADDR == $past(CTRL_ADDR))
      else $error("controller address not loaded");
   chk_local_ign: assert property (
      PROTO_EN && !CTRL_ADDR_VALID |=> $stable(NET_ADDR))
      else $error("address changed without controller");
endmodule // slot_mapper_assertions

bind process_data_slot_mapper slot_mapper_assertions #(.NSLOT(NSLOT),
   .RW(RW)) u_sva (.CLK(CLK), .RST(RST), .CFG_VALID(CFG_VALID),
   .CFG_SLOT(CFG_SLOT), .CFG_MOD_ID(CFG_MOD_ID), .CFG_ACCEPT(CFG_ACCEPT),
   .CFG_REJECT(CFG_REJECT), .SLOT_PLUGGED(SLOT_PLUGGED),
   .OUT_VALID(OUT_VALID), .OUT_SLOT(OUT_SLOT), .OUT_INDEX(OUT_INDEX),
   .LR_WR_EN(LR_WR_EN), .LR_WR_ADDR(LR_WR_ADDR), .PROTO_EN(PROTO_EN),
   .CTRL_ADDR_VALID(CTRL_ADDR_VALID), .CTRL_ADDR(CTRL_ADDR),
   .NET_ADDR(NET_ADDR));

// ---- regstore_model.sv ----
`timescale 1ns/1ps
// Local register store, one cycle read latency
module regstore_model (
   input wire clk,
   input wire rd_en,
   input wire [15:0] rd_addr,
   output reg [15:0] rd_data
);
   initial rd_data = 16'h0000;
   // Idle bus flips each cycle so stale data never looks valid
   always @(posedge clk) begin
      if (rd_en) begin
         rd_data <= rd_addr ^ 16'h5A5A;
      end else begin
         rd_data <= ~rd_data;
      end
   end
endmodule // regstore_model

// ---- tb_process_data_slot_mapper.sv ----
`timescale 1ns/1ps
module tb_process_data_slot_mapper;
   reg CLK = 0;
   reg RST = 1;
   reg CFG_VALID = 0;
   reg [3:0] CFG_SLOT = 0;
   reg [7:0] CFG_MOD_ID = 0;
   reg IN_REQ = 0;
   reg [3:0] IN_SLOT = 0;
   reg [7:0] IN_INDEX = 0;
   reg OUT_VALID = 0;
   reg [3:0] OUT_SLOT = 0;
   reg [7:0] OUT_INDEX = 0;
   reg [15:0] OUT_DATA = 0;
   reg PROTO_EN = 0;
   reg LOCAL_ADDR_VALID = 0;
   reg [31:0] LOCAL_ADDR = 0;
   reg CTRL_ADDR_VALID = 0;
   reg [31:0] CTRL_ADDR = 0;
   wire ack, rej, in_ack, in_err, rd_en, wr_en, out_err;
   wire cfg_rdy, out_rdy;
   wire [8:0] bad, plugged;
   wire [31:0] in_data, net;
   wire [15:0] rd_addr, rd_data, wr_addr, wr_data;
   integer fails = 0;
   integer checks = 0;
   integer i;
   process_data_slot_mapper u_dut (.CLK(CLK), .RST(RST),
      .CFG_VALID(CFG_VALID), .CFG_SLOT(CFG_SLOT), .CFG_SUBSLOT(4'h1),
      .CFG_MOD_ID(CFG_MOD_ID), .CFG_READY(cfg_rdy), .CFG_ACCEPT(ack),
      .CFG_REJECT(rej), .SLOT_BAD(bad), .SLOT_PLUGGED(plugged),
      .IN_REQ(IN_REQ), .IN_SLOT(IN_SLOT), .IN_INDEX(IN_INDEX),
      .IN_ACK(in_ack), .IN_ERR(in_err), .IN_DATA(in_data),
      .LR_RD_EN(rd_en), .LR_RD_ADDR(rd_addr), .LR_RD_DATA(rd_data),
      .OUT_VALID(OUT_VALID), .OUT_SLOT(OUT_SLOT), .OUT_INDEX(OUT_INDEX),
      .OUT_DATA(OUT_DATA), .OUT_READY(out_rdy), .OUT_ERR(out_err),
      .LR_WR_EN(wr_en), .LR_WR_ADDR(wr_addr), .LR_WR_DATA(wr_data),
      .PROTO_EN(PROTO_EN), .LOCAL_ADDR_VALID(LOCAL_ADDR_VALID),
      .LOCAL_ADDR(LOCAL_ADDR), .CTRL_ADDR_VALID(CTRL_ADDR_VALID),
      .CTRL_ADDR(CTRL_ADDR), .NET_ADDR(net));
   regstore_model u_regs (.clk(CLK), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data));
   // Clock
   always #50 CLK = ~CLK;
   // ****
   // Shared tasks
   // ****
   function [15:0] d(input [15:0] a);
      d = a ^ 16'h5A5A;
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // One plug request, answer one cycle later
   task plug(input [3:0] s, input [7:0] id, input ok);
      begin
         @(negedge CLK);
         CFG_SLOT = s;
         CFG_MOD_ID = id;
         CFG_VALID = 1;
         @(negedge CLK);
         CFG_VALID = 0;
         chk("accept", {31'h0, ok}, {31'h0, ack});
         chk("reject", {31'h0, !ok}, {31'h0, rej});
         chk("cfg_ready", 1, {31'h0, cfg_rdy});
      end
   endtask
   // Input read; bounded wait since float reads take longer
   task rd(input [3:0] s, input [7:0] ix, input er, input [31:0] e);
      integer n;
      begin
         @(negedge CLK);
         IN_SLOT = s;
         IN_INDEX = ix;
         IN_REQ = 1;
         @(negedge CLK);
         IN_REQ = 0;
         n = 0;
         while (in_ack !== 1'b1 && n < 10) begin
            @(negedge CLK);
            n = n + 1;
         end
         chk("in_ack", 1, {31'h0, in_ack});
         chk("in_err", {31'h0, er}, {31'h0, in_err});
         if (!er) chk("in_data", e, in_data);
      end
   endtask
   // Output beat; address zero means the beat must fail
   task wr(input [3:0] s, input [7:0] ix, input [15:0] a);
      begin
         @(negedge CLK);
         OUT_SLOT = s;
         OUT_INDEX = ix;
         OUT_DATA = ~a;
         OUT_VALID = 1;
         @(negedge CLK);
         OUT_VALID = 0;
         chk("wr_en", {31'h0, a != 0}, {31'h0, wr_en});
         chk("out_err", {31'h0, a == 0}, {31'h0, out_err});
         chk("out_ready", 1, {31'h0, out_rdy});
         if (a != 0) chk("wr_addr", {16'h0, a}, {16'h0, wr_addr});
         if (a != 0) chk("wr_data", {16'h0, ~a}, {16'h0, wr_data});
      end
   endtask
   // ****
   // Scenarios
   // ****
   task t_plug;
      begin
         chk("plugged_rst", 0, {23'h0, plugged});
         plug(4'h0, 8'h30, 0);
         plug(4'hA, 8'h40, 0);
         plug(4'h1, 8'h30, 1);
         plug(4'h2, 8'h32, 1);
         for (i = 0; i < 4; i = i + 1) plug(4'h3, 8'h30 + i[7:0], 1);
         plug(4'h3, 8'h40, 0);
         for (i = 0; i < 4; i = i + 1) plug(4'h6, 8'h34 + i[7:0], 1);
         plug(4'h4, 8'h36, 1);
         plug(4'h5, 8'h31, 0);
         for (i = 0; i < 4; i = i + 1) plug(4'h9, 8'h40 + i[7:0], 1);
         plug(4'h7, 8'h43, 1);
         chk("plugged", 32'h16B, {23'h0, plugged});
         chk("bad", 32'h014, {23'h0, bad});
         $display("test plug done");
      end
   endtask
   task t_read;
      begin
         rd(4'h1, 8'hFF, 0, {16'h0, d(16'd256)});
         rd(4'h2, 8'h00, 0, {16'h0, d(16'd257)});
         rd(4'h2, 8'h40, 1, 0);
         rd(4'h4, 8'h01, 0, {d(16'd1003), d(16'd1004)});
         rd(4'h4, 8'h20, 1, 0);
         rd(4'h3, 8'h00, 1, 0);
         rd(4'h7, 8'h00, 1, 0);
         $display("test read done");
      end
   endtask
   task t_write;
      begin
         wr(4'h7, 8'h00, 16'd5001);
         wr(4'h7, 8'h1F, 16'd5032);
         wr(4'h7, 8'h20, 16'h0);
         wr(4'h1, 8'h00, 16'h0);
         $display("test write done");
      end
   endtask
   task t_addr;
      begin
         @(negedge CLK);
         PROTO_EN = 1;
         LOCAL_ADDR = 32'hC0A80001;
         LOCAL_ADDR_VALID = 1;
         @(negedge CLK);
         LOCAL_ADDR_VALID = 0;
         chk("net_ign", 0, net);
         CTRL_ADDR = 32'h0A000002;
         CTRL_ADDR_VALID = 1;
         @(negedge CLK);
         CTRL_ADDR_VALID = 0;
         chk("net_ctrl", 32'h0A000002, net);
         PROTO_EN = 0;
         LOCAL_ADDR_VALID = 1;
         @(negedge CLK);
         LOCAL_ADDR_VALID = 0;
         chk("net_local", 32'hC0A80001, net);
         $display("test addr done");
      end
   endtask
   // Mid-run reset must unplug every slot and clear the address
   task t_reset;
      begin
         @(negedge CLK);
         RST = 1;
         @(negedge CLK);
         RST = 0;
         chk("plugged_clr", 0, {23'h0, plugged});
         chk("bad_clr", 0, {23'h0, bad});
         chk("net_clr", 0, net);
         rd(4'h1, 8'h00, 1, 0);
         $display("test reset done");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      repeat (5) @(negedge CLK);
      RST = 0;
      t_plug;
      t_read;
      t_write;
      t_addr;
      t_reset;
      end_of_test;
   end
   // Watchdog, far beyond the under a hundred cycles needed
   initial begin
      #2000000;
      fails = fails + 1;
      end_of_test;
   end
endmodule // tb_process_data_slot_mapper
